// file: rtl/csf_pkg.sv
/*
 * csf_pkg: constants for the completion sideband framing decoder.
 * Assumes a single 50 MHz clock domain and a 32-bit AXI4-Lite register bus.
 */
package csf_pkg;
    // completion sideband layout
    localparam int SB_W = 81;
    localparam int SOP_LO = 0;
    localparam int SOP0_PTR_LO = 2;
    localparam int SOP1_PTR_LO = 4;
    localparam int EOP_LO = 6;
    localparam int EOP0_PTR_LO = 8;
    localparam int EOP1_PTR_LO = 12;
    localparam int KEEP_W = 16;
    // start pointer codes and the byte lanes they name
    localparam logic [1:0] PTR_LANE0 = 2'h0;
    localparam logic [1:0] PTR_LANE32 = 2'h2;
    localparam logic [5:0] LANE_0 = 6'h00;
    localparam logic [5:0] LANE_32 = 6'h20;
    // two-bit flag codes
    localparam logic [1:0] FLG_NONE = 2'h0;
    localparam logic [1:0] FLG_ONE = 2'h1;
    localparam logic [1:0] FLG_RSVD = 2'h2;
    localparam logic [1:0] FLG_TWO = 2'h3;
    // register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    localparam int CTRL_STRADDLE_BIT = 0;
    localparam int STAT_OPEN_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam logic CTRL_STRADDLE_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : csf_pkg

// file: rtl/csf_beat_if.sv
/*
 * csf_beat_if: raw framing fields in, decoded framing out, between the
 * framer top and its decoder. Assumes both ends sit on one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface csf_beat_if;
    import csf_pkg::*;
    logic straddle;
    logic open_tlp;
    logic [SB_W-1:0] sideband;
    logic last;
    logic [KEEP_W-1:0] keep;
    logic [1:0] sop_flags;
    logic [5:0] first_lane;
    logic [5:0] second_lane;
    logic [1:0] eop_flags;
    logic [3:0] first_off;
    logic [3:0] second_off;
    logic bad_code;
    modport dec (input straddle, open_tlp, sideband, last, keep,
                 output sop_flags, first_lane, second_lane, eop_flags,
                 first_off, second_off, bad_code);
    modport top (output straddle, open_tlp, sideband, last, keep,
                 input sop_flags, first_lane, second_lane, eop_flags,
                 first_off, second_off, bad_code);
endinterface : csf_beat_if
`default_nettype wire

// file: rtl/csf_decode.sv
/*
 * csf_decode: combinational decode of one completion beat's framing.
 * Assumes the caller qualifies the result with its own valid and ready.
 */
`timescale 1ns/10ps
`default_nettype none
module csf_decode (
    // framing fields and decoded result
    csf_beat_if.dec bi
);
    import csf_pkg::*;

    logic [1:0] sop_raw;
    logic [1:0] ptr0;
    logic [1:0] ptr1;
    logic [1:0] eop_raw;
    logic [3:0] keep_top;

    assign sop_raw = bi.sideband[SOP_LO +: 2];
    assign ptr0 = bi.sideband[SOP0_PTR_LO +: 2];
    assign ptr1 = bi.sideband[SOP1_PTR_LO +: 2];
    assign eop_raw = bi.sideband[EOP_LO +: 2];

    // highest kept dword marks the end when not straddling
    always_comb
    begin
        keep_top = 4'h0;
        for (int i = 0; i < KEEP_W; i++)
        begin
            if (bi.keep[i])
            begin
                keep_top = 4'(i);
            end
        end
    end

    always_comb
    begin
        bi.sop_flags = FLG_NONE;
        bi.first_lane = LANE_0;
        bi.second_lane = LANE_0;
        bi.eop_flags = FLG_NONE;
        bi.first_off = 4'h0;
        bi.second_off = 4'h0;
        bi.bad_code = 1'b0;
        if (bi.straddle)
        begin
            bi.sop_flags = sop_raw;
            bi.eop_flags = eop_raw;
            if (sop_raw == FLG_RSVD || eop_raw == FLG_RSVD)
            begin
                bi.bad_code = 1'b1;
            end
            if (sop_raw[0])
            begin
                bi.first_lane = (ptr0 == PTR_LANE32) ? LANE_32 : LANE_0;
                if (ptr0 != PTR_LANE0 && ptr0 != PTR_LANE32)
                begin
                    bi.bad_code = 1'b1;
                end
            end
            if (sop_raw == FLG_TWO)
            begin
                bi.second_lane = LANE_32;
                if (ptr1 != PTR_LANE32)
                begin
                    bi.bad_code = 1'b1;
                end
            end
            // offsets pass only under their own end flag
            if (eop_raw[0])
            begin
                bi.first_off = bi.sideband[EOP0_PTR_LO +: 4];
            end
            if (eop_raw == FLG_TWO)
            begin
                bi.second_off = bi.sideband[EOP1_PTR_LO +: 4];
            end
        end
        else
        begin
            // upper flag bits and the sideband flags ignored here
            bi.sop_flags = {1'b0, ~bi.open_tlp};
            bi.eop_flags = {1'b0, bi.last};
            bi.first_off = bi.last ? keep_top : 4'h0;
        end
    end
endmodule : csf_decode
`default_nettype wire

// file: rtl/csf_framer.sv
/*
 * csf_framer: completion stream framing decoder with AXI4-Lite control.
 * Assumes the sender keeps the stream handshake and drives no reserved
 * codes; the framing outputs feed logic on the same clock.
 */
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module csf_framer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // completion stream from the sender
    input wire logic completion_valid,
    output logic completion_ready,
    input wire logic [csf_pkg::SB_W-1:0] completion_sideband,
    input wire logic completion_last,
    input wire logic [csf_pkg::KEEP_W-1:0] completion_keep,
    // decoded framing towards the core
    output logic beat_valid,
    input wire logic beat_ready,
    output logic [1:0] tlp_start_flags,
    output logic [5:0] first_start_lane,
    output logic [5:0] second_start_lane,
    output logic [1:0] tlp_end_flags,
    output logic [3:0] first_end_dword_offset,
    output logic [3:0] second_end_dword_offset,
    // axi4-lite write
    input wire logic [csf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [csf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import csf_pkg::*;

    typedef struct packed {
        logic ready;
        logic bv;
        logic [1:0] sop;
        logic [5:0] lane0;
        logic [5:0] lane1;
        logic [1:0] eop;
        logic [3:0] off0;
        logic [3:0] off1;
        logic open_tlp;
        logic straddle;
        logic err;
        logic [31:0] count;
        logic awready;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic wready;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } csf_state_t;

    csf_state_t st_q;
    csf_state_t st_d;
    csf_beat_if bi ();
    logic take;
    logic [1:0] n_sop;
    logic [1:0] n_eop;

    assign bi.straddle = st_q.straddle;
    assign bi.open_tlp = st_q.open_tlp;
    assign bi.sideband = completion_sideband;
    assign bi.last = completion_last;
    assign bi.keep = completion_keep;

    csf_decode u_dec (
        .bi(bi)
    );

    // fields are looked at only on an accepted beat
    assign take = completion_valid && st_q.ready;
    assign n_sop = 2'(bi.sop_flags[0]) + 2'(bi.sop_flags[1]);
    assign n_eop = 2'(bi.eop_flags[0]) + 2'(bi.eop_flags[1]);

    always_comb
    begin
        st_d = st_q;
        // one output stage; trades half rate for a flop-driven ready
        if (st_q.bv && beat_ready)
        begin
            st_d.bv = 1'b0;
        end
        if (take)
        begin
            st_d.bv = 1'b1;
            st_d.sop = bi.sop_flags;
            st_d.lane0 = bi.first_lane;
            st_d.lane1 = bi.second_lane;
            st_d.eop = bi.eop_flags;
            st_d.off0 = bi.first_off;
            st_d.off1 = bi.second_off;
            // a packet stays open if its start outlives the ends seen
            st_d.open_tlp = st_q.straddle
                ? ((2'(st_q.open_tlp) + n_sop) != n_eop)
                : ~completion_last;
            st_d.count = st_q.count + 32'(n_eop);
        end
        st_d.ready = ~st_d.bv;
        // write channel: address and data in either order
        if (s_axi_awvalid && st_q.awready)
        begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wready)
        begin
            st_d.w_have = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
        end
        else if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
        begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            unique case (st_q.aw_addr)
                REG_CTRL:
                begin
                    if (st_q.wstrb[0])
                    begin
                        st_d.straddle = st_q.wdata[CTRL_STRADDLE_BIT];
                    end
                end
                REG_STATUS:
                begin
                    if (st_q.wstrb[0] && st_q.wdata[STAT_ERR_BIT])
                    begin
                        st_d.err = 1'b0;
                    end
                end
                REG_COUNT:
                begin
                    if (st_q.wstrb != 4'h0)
                    begin
                        st_d.count = 32'h0;
                    end
                end
                default:
                begin
                    st_d.bresp = RESP_DECERR;
                end
            endcase
        end
        // a reserved code seen on the same edge as the clear still sticks
        if (take && bi.bad_code)
        begin
            st_d.err = 1'b1;
        end
        st_d.awready = ~st_d.aw_have && ~st_d.bvalid;
        st_d.wready = ~st_d.w_have && ~st_d.bvalid;
        // read channel
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
        end
        else if (s_axi_arvalid && st_q.arready)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            st_d.rdata = 32'h0;
            unique case (s_axi_araddr)
                REG_CTRL:
                begin
                    st_d.rdata[CTRL_STRADDLE_BIT] = st_q.straddle;
                end
                REG_STATUS:
                begin
                    st_d.rdata[STAT_OPEN_BIT] = st_q.open_tlp;
                    st_d.rdata[STAT_ERR_BIT] = st_q.err;
                end
                REG_COUNT:
                begin
                    st_d.rdata = st_q.count;
                end
                default:
                begin
                    st_d.rresp = RESP_DECERR;
                end
            endcase
        end
        st_d.arready = ~st_d.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
            st_q.straddle <= CTRL_STRADDLE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign completion_ready = st_q.ready;
    assign beat_valid = st_q.bv;
    assign tlp_start_flags = st_q.sop;
    assign first_start_lane = st_q.lane0;
    assign second_start_lane = st_q.lane1;
    assign tlp_end_flags = st_q.eop;
    assign first_end_dword_offset = st_q.off0;
    assign second_end_dword_offset = st_q.off1;
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    beat_load_a: assert property ($rose(st_q.bv) |-> $past(completion_valid && st_q.ready))
        else $error("beat loaded without a handshake");
    no_valid_a: assert property (!completion_valid |=> !$rose(st_q.bv))
        else $error("beat loaded while valid was low");
    upper_sop_a: assert property (completion_valid && st_q.ready && !st_q.straddle
        |=> st_q.sop[1] == 1'b0 && st_q.lane0 == LANE_0)
        else $error("upper start flag used without straddle");
    first_beat_a: assert property (completion_valid && st_q.ready && !st_q.straddle
        |=> st_q.sop[0] == !$past(st_q.open_tlp))
        else $error("first beat does not follow last beat");
    end_last_a: assert property (completion_valid && st_q.ready && !st_q.straddle
        |=> st_q.eop == {1'b0, $past(completion_last)})
        else $error("end flags not taken from last");
    lane_code_a: assert property (st_q.bv && st_q.straddle && st_q.sop == FLG_TWO
        |-> st_q.lane1 == LANE_32 && (st_q.lane0 == LANE_0 || st_q.lane0 == LANE_32))
        else $error("start lane outside lane 0 or 32");
    off_gate_a: assert property (st_q.bv |-> (st_q.eop[0] || st_q.off0 == 4'h0)
        && (st_q.eop[1] || st_q.off1 == 4'h0))
        else $error("end offset shown without its flag");
    rsvd_flag_a: assert property (completion_valid && st_q.ready && st_q.straddle
        && completion_sideband[SOP_LO +: 2] == FLG_RSVD |=> st_q.err)
        else $error("reserved start code not flagged");
    ptr_honour_a: assert property (completion_valid && st_q.ready && st_q.straddle
        && completion_sideband[SOP_LO +: 2] == FLG_TWO
        && completion_sideband[SOP1_PTR_LO +: 2] != PTR_LANE32 |=> st_q.err)
        else $error("bad second start pointer not flagged");
endmodule : csf_framer
`default_nettype wire

// file: test/csf_sender.sv
/*
 * csf_sender: behavioural sender of completion beats into the framer.
 * Assumes the bench raises go for one edge with the fields already set.
 */
`timescale 1ns/10ps
`default_nettype none
module csf_sender (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request from the bench
    input wire logic go,
    input wire logic [15:0] fields,
    input wire logic last_in,
    input wire logic [15:0] keep_in,
    output logic done,
    // completion stream
    output logic completion_valid,
    input wire logic completion_ready,
    output logic [80:0] completion_sideband,
    output logic completion_last,
    output logic [15:0] completion_keep
);
    always_ff @(posedge aclk)
    begin
        done <= 1'b0;
        if (!aresetn)
        begin
            completion_valid <= 1'b0;
            completion_sideband <= 81'h0;
            completion_last <= 1'b0;
            completion_keep <= 16'h0;
        end
        else if (go && !completion_valid)
        begin
            completion_valid <= 1'b1;
            // reserved codes only when the bench asks for them
            completion_sideband <= {65'h0, fields};
            completion_last <= last_in;
            completion_keep <= keep_in;
        end
        else if (completion_valid && completion_ready)
        begin
            completion_valid <= 1'b0;
            // idle bus shows junk so stale fields cannot pass unnoticed
            completion_sideband <= ~completion_sideband;
            completion_last <= ~completion_last;
            completion_keep <= ~completion_keep;
            done <= 1'b1;
        end
    end
endmodule : csf_sender
`default_nettype wire

// file: test/testbench.sv
/*
 * testbench: self-checking bench for csf_framer.
 * Assumes the sender model in csf_sender.sv and the rtl package.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import csf_pkg::*;
    logic aclk, aresetn, go, last_in, done, cv, cr, cl, bv, br;
    logic [15:0] fields, keep_in, ck;
    logic [80:0] csb;
    logic [1:0] sf, ef, bresp, rresp;
    logic [5:0] l0, l1;
    logic [3:0] o0, o1, awaddr, araddr, wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] rsp;
    int miscompares = 0, n_checks = 0, cycles = 0;

    csf_sender csf_sender_inst (.aclk(aclk), .aresetn(aresetn), .go(go), .fields(fields),
        .last_in(last_in), .keep_in(keep_in), .done(done), .completion_valid(cv),
        .completion_ready(cr), .completion_sideband(csb), .completion_last(cl),
        .completion_keep(ck));
    csf_framer csf_framer_inst (.aclk(aclk), .aresetn(aresetn), .completion_valid(cv),
        .completion_ready(cr), .completion_sideband(csb), .completion_last(cl),
        .completion_keep(ck), .beat_valid(bv), .beat_ready(br), .tlp_start_flags(sf),
        .first_start_lane(l0), .second_start_lane(l1), .tlp_end_flags(ef),
        .first_end_dword_offset(o0), .second_end_dword_offset(o1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdw(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rdw

    function automatic logic [15:0] mk(input logic [1:0] s, p0, p1, e, input logic [3:0] a, b);
        return {b, a, e, p1, p0, s};
    endfunction : mk

    // one beat through; decoded fields packed as start,lane0,lane1,end,off0,off1
    task automatic beat(input logic [15:0] f, input logic last, input logic [15:0] keep,
                        input logic [23:0] exp, input logic [23:0] mask);
        @(posedge aclk);
        fields <= f;
        last_in <= last;
        keep_in <= keep;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(negedge aclk);
        while (bv !== 1'b1) @(negedge aclk);
        chk("sender done", 1, done);
        chk("framing", exp, {sf, l0, l1, ef, o0, o1} & mask);
        repeat (2) @(negedge aclk);
        chk("held framing", exp, {sf, l0, l1, ef, o0, o1} & mask);
        chk("ready while held", 0, cr);
        @(posedge aclk);
        br <= 1'b1;
        @(posedge aclk);
        br <= 1'b0;
    endtask : beat

    task automatic s_regs;
        rdw(REG_CTRL);
        chk("ctrl reset", 0, rd);
        rdw(4'hc);
        chk("unmapped read", RESP_DECERR, rsp);
        wr(4'hc, 32'h1);
        chk("unmapped write", RESP_DECERR, rsp);
    endtask : s_regs

    task automatic s_plain;
        beat(mk(2'h3, 2'h2, 2'h2, 2'h0, 4'h5, 4'h6), 1'b1, 16'h00ff,
             {2'h1, 6'h0, 6'h0, 2'h1, 4'h7, 4'h0}, 24'hffffff);
        beat(mk(2'h0, 2'h0, 2'h0, 2'h3, 4'h1, 4'h1), 1'b0, 16'hffff,
             {2'h1, 6'h0, 6'h0, 2'h0, 4'h0, 4'h0}, 24'hffffff);
        rdw(REG_STATUS);
        chk("tlp open", 1, rd[STAT_OPEN_BIT]);
        beat(mk(2'h1, 2'h0, 2'h2, 2'h0, 4'h0, 4'h0), 1'b1, 16'hffff,
             {2'h0, 6'h0, 6'h0, 2'h1, 4'hf, 4'h0}, 24'hffffff);
    endtask : s_plain

    task automatic s_straddle;
        wr(REG_CTRL, 32'h1);
        chk("ctrl write resp", RESP_OKAY, rsp);
        rdw(REG_CTRL);
        chk("ctrl", 1, rd);
        chk("ctrl read resp", RESP_OKAY, rsp);
        beat(mk(2'h3, 2'h0, 2'h2, 2'h3, 4'h3, 4'h9), 1'b0, 16'h0,
             {2'h3, 6'h0, 6'h20, 2'h3, 4'h3, 4'h9}, 24'hffffff);
        beat(mk(2'h1, 2'h2, 2'h2, 2'h1, 4'h5, 4'h0), 1'b1, 16'h1,
             {2'h1, 6'h20, 6'h0, 2'h1, 4'h5, 4'h0}, 24'hffffff);
    endtask : s_straddle

    task automatic s_reserved;
        wr(REG_STATUS, 32'h2);
        beat(mk(2'h2, 2'h0, 2'h0, 2'h0, 4'h0, 4'h0), 1'b0, 16'h0,
             {2'h0, 18'h0, 4'h0}, 24'h3fffff);
        rdw(REG_STATUS);
        chk("reserved sticky", 1, rd[STAT_ERR_BIT]);
        wr(REG_STATUS, 32'h2);
        rdw(REG_STATUS);
        chk("error cleared", 0, rd[STAT_ERR_BIT]);
        // second start pointer off lane 32 must also raise the error
        beat(mk(2'h3, 2'h0, 2'h0, 2'h0, 4'h0, 4'h0), 1'b0, 16'h0,
             {2'h3, 6'h0, 6'h0, 2'h0, 4'h0, 4'h0}, 24'hff03ff);
        rdw(REG_STATUS);
        chk("bad second pointer", 1, rd[STAT_ERR_BIT]);
        wr(REG_STATUS, 32'h2);
        // ends so far: two plain last beats, then two and one straddled
        rdw(REG_COUNT);
        chk("tlp end count", 5, rd);
        wr(REG_COUNT, 32'h0);
        rdw(REG_COUNT);
        chk("count cleared", 0, rd);
        wr(REG_CTRL, 32'h0);
    endtask : s_reserved

    initial
    begin
        aresetn = 1'b0;
        {go, last_in, br, awvalid, wvalid, bready, arvalid, rready} = '0;
        {fields, keep_in, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs();
        s_plain();
        s_straddle();
        s_reserved();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
